// File: ppc_pkg.sv
// package: register map, field layout, reset values and carriers for pll ctrl
package ppc_pkg;

  // ****************************************************************
  // register map (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [4:0] PPC_REG_CFG      = 5'h00;
  localparam logic [4:0] PPC_REG_DIV      = 5'h04;
  localparam logic [4:0] PPC_REG_STATUS   = 5'h08;
  localparam logic [4:0] PPC_REG_IRQ_STAT = 5'h0C;
  localparam logic [4:0] PPC_REG_IRQ_MASK = 5'h10;
  localparam logic [4:0] PPC_REG_OUT_CFG  = 5'h14;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PPC_CFG_N_POS   = 0;   // pre-scale minus one, 2 bits
  localparam int PPC_CFG_M_POS   = 8;   // feedback minus one, 5 bits
  localparam int PPC_DIV_C0_POS  = 0;   // post-scale minus one, 5 bits each
  localparam int PPC_DIV_C1_POS  = 8;
  localparam int PPC_DIV_C2_POS  = 16;
  localparam int PPC_ST_LOCK_POS = 0;
  localparam int PPC_ST_SEL_POS  = 1;
  localparam int PPC_ST_RUN_POS  = 2;
  localparam int PPC_ST_DET_POS  = 3;
  localparam int PPC_ST_PER_POS  = 16;  // current oscillator period
  localparam int PPC_IRQ_GAIN    = 0;   // lock gained
  localparam int PPC_IRQ_LOST    = 1;   // lock lost
  localparam int PPC_IRQ_SWITCH  = 2;   // reference switched
  localparam int PPC_OUT_EXT_POS = 0;   // external pin enable

  // ****************************************************************
  // reset values and counts
  // ****************************************************************
  localparam logic [1:0]  PPC_N_RST       = 2'h0;   // n = 1
  localparam logic [4:0]  PPC_M_RST       = 5'h07;  // m = 8
  localparam logic [14:0] PPC_C_RST       = 15'h0000;
  localparam logic        PPC_EXT_RST     = 1'b0;
  localparam logic [2:0]  PPC_MASK_RST    = 3'h0;
  localparam logic [15:0] PPC_PERIOD_RST  = 16'h0008;
  localparam logic [15:0] PPC_PERIOD_MIN  = 16'h0001;
  localparam logic [15:0] PPC_PERIOD_MAX  = 16'hFFFF;
  localparam logic [3:0]  PPC_LOCK_CMP    = 4'h8;   // matched compares
  localparam logic [5:0]  PPC_FB_SAT      = 6'h3F;
  localparam int          PPC_SYNC_W      = 6;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic enable;      // loop enable, active high
    logic cnt_reset;   // counter reset, active high
    logic det_enable;  // phase detector enable, active high
    logic switch_req;  // manual reference switchover request
    logic ref_sec;     // secondary reference clock pin
    logic ref_pri;     // primary reference clock pin
  } ppc_pins_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } ppc_av_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } ppc_av_rsp_t;

  typedef struct packed {
    logic [PPC_SYNC_W-1:0] s1;
    logic [PPC_SYNC_W-1:0] s2;
    logic [PPC_SYNC_W-1:0] s3;
    logic [PPC_SYNC_W-1:0] flt;
  } ppc_sync_t;

endpackage : ppc_pkg

// File: ppc_in_sync.sv
// three-stage synchroniser with agreement filter for the control pins and both reference clocks
`timescale 1ns/1ps
module ppc_in_sync
(
  input  wire logic                           ref_clk_in,
  input  wire logic                           reset_in,
  input  wire logic [ppc_pkg::PPC_SYNC_W-1:0] raw_in,
  output logic      [ppc_pkg::PPC_SYNC_W-1:0] flt_out
);
  import ppc_pkg::*;

  ppc_sync_t q;
  ppc_sync_t d;

  // ****************************************************************
  // next state
  // ****************************************************************
  // first stage is read only by the second; the filter looks at 2 and 3
  always_comb
  begin
    d     = q;
    d.s1  = raw_in;
    d.s2  = q.s1;
    d.s3  = q.s2;
    for (int i = 0; i < PPC_SYNC_W; i++)
    begin
      if (q.s2[i] == q.s3[i])
        d.flt[i] = q.s3[i];
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      q <= '0;
    else
      q <= d;
  end

  assign flt_out = q.flt;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  chk_sync_agree: assert property (
    (q.s2 == q.s3) |=> (q.flt == $past(q.s3)))
    else $error("filtered input did not follow agreeing stages");

endmodule : ppc_in_sync

// File: ppc_pll_ctrl.sv
// pll port control: reference select, counters, detector, lock, register bus
`timescale 1ns/1ps
module ppc_pll_ctrl
(
  input  wire logic                ref_clk_in,
  input  wire logic                reset_in,
  input  wire ppc_pkg::ppc_pins_t  pins_in,
  input  wire ppc_pkg::ppc_av_req_t avs_req_in,
  output ppc_pkg::ppc_av_rsp_t     avs_rsp_out,
  output logic [2:0]               pll_clk_out,
  output logic                     ext_clk_out,
  output logic                     locked_out,
  output logic                     irq_out
);
  import ppc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic        sel;       // 0 primary, 1 secondary
    logic        ref_prev;
    logic        sw_prev;
    logic        run_prev;
    logic [1:0]  n_cnt;
    logic [5:0]  fb_cnt;    // oscillator ticks since last compare
    logic [15:0] period;
    logic [15:0] phase;
    logic [14:0] c_cnt;
    logic [2:0]  clk;
    logic        ext;
    logic        locked;
    logic [3:0]  match;
    logic [1:0]  n_cfg;
    logic [4:0]  m_cfg;
    logic [14:0] c_cfg;
    logic        ext_en;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        irq;
    logic        waitreq;
    logic [31:0] rdata;
  } ppc_state_t;

  ppc_state_t q;
  ppc_state_t d;
  ppc_pins_t  f;
  logic [PPC_SYNC_W-1:0] f_bits;

  ppc_in_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .raw_in     (PPC_SYNC_W'(pins_in)),
    .flt_out    (f_bits)
  );
  assign f = ppc_pins_t'(f_bits);

  logic        run;
  logic        sel_ref;
  logic        ref_rise;
  logic        sw_rise;
  logic        restart;
  logic        tick;
  logic        fref;
  logic [5:0]  m_val;
  logic [2:0]  ev;
  logic [2:0]  w1c;
  logic        req;
  logic [31:0] wd;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    d        = q;
    ev       = 3'h0;
    w1c      = 3'h0;
    tick     = 1'b0;
    fref     = 1'b0;
    wd       = avs_req_in.writedata;
    req      = avs_req_in.read | avs_req_in.write;
    m_val    = {1'b0, q.m_cfg} + 6'h01;
    run      = f.enable & ~f.cnt_reset;
    sel_ref  = q.sel ? f.ref_sec : f.ref_pri;
    ref_rise = sel_ref & ~q.ref_prev;
    sw_rise  = f.switch_req & ~q.sw_prev;
    restart  = run & ~q.run_prev;
    d.ref_prev = sel_ref;
    d.sw_prev  = f.switch_req;
    d.run_prev = run;

    // bus slave: one wait cycle, then the request is taken
    d.waitreq = ~(req & q.waitreq);
    if (req & q.waitreq)
    begin
      if (avs_req_in.address == PPC_REG_CFG)
        d.rdata = 32'({q.m_cfg, 6'h00, q.n_cfg});
      else if (avs_req_in.address == PPC_REG_DIV)
        d.rdata = 32'({q.c_cfg[14:10], 3'h0, q.c_cfg[9:5], 3'h0,
                       q.c_cfg[4:0]});
      else if (avs_req_in.address == PPC_REG_STATUS)
        d.rdata = {q.period, 12'h000, f.det_enable, run, q.sel,
                   q.locked};
      else if (avs_req_in.address == PPC_REG_IRQ_STAT)
        d.rdata = 32'(q.irq_stat);
      else if (avs_req_in.address == PPC_REG_IRQ_MASK)
        d.rdata = 32'(q.irq_mask);
      else if (avs_req_in.address == PPC_REG_OUT_CFG)
        d.rdata = 32'(q.ext_en);
      else
        d.rdata = 32'h0000_0000;  // unmapped reads zero
    end
    if (avs_req_in.write & ~q.waitreq)
    begin
      if (avs_req_in.address == PPC_REG_CFG)
      begin
        d.n_cfg = wd[PPC_CFG_N_POS +: 2];
        d.m_cfg = wd[PPC_CFG_M_POS +: 5];
      end
      else if (avs_req_in.address == PPC_REG_DIV)
        d.c_cfg = {wd[PPC_DIV_C2_POS +: 5], wd[PPC_DIV_C1_POS +: 5],
                   wd[PPC_DIV_C0_POS +: 5]};
      else if (avs_req_in.address == PPC_REG_IRQ_STAT)
        w1c = wd[2:0];
      else if (avs_req_in.address == PPC_REG_IRQ_MASK)
        d.irq_mask = wd[2:0];
      else if (avs_req_in.address == PPC_REG_OUT_CFG)
        d.ext_en = wd[PPC_OUT_EXT_POS];
    end

    // loop: stopped, restarting, or running
    if (!run)
    begin
      // counters back to start, clocks low, lock gone
      d.n_cnt  = 2'h0;
      d.fb_cnt = 6'h00;
      d.c_cnt  = 15'h0000;
      d.phase  = 16'h0000;
      d.period = PPC_PERIOD_RST;
      d.clk    = 3'h0;
      d.locked = 1'b0;
      d.match  = 4'h0;
    end
    else if (restart | sw_rise)
    begin
      // fresh acquisition against the (new) reference
      d.n_cnt  = 2'h0;
      d.fb_cnt = 6'h00;
      d.c_cnt  = 15'h0000;
      d.phase  = 16'h0000;
      d.locked = 1'b0;
      d.match  = 4'h0;
      if (sw_rise)
      begin
        d.sel = ~q.sel;
        ev[PPC_IRQ_SWITCH] = 1'b1;
      end
    end
    else
    begin
      // oscillator keeps running whatever the detector does
      if (q.phase >= q.period)
      begin
        tick    = 1'b1;
        d.phase = 16'h0000;
      end
      else
        d.phase = q.phase + 16'h0001;
      if (tick)
      begin
        if (q.fb_cnt != PPC_FB_SAT)
          d.fb_cnt = q.fb_cnt + 6'h01;
        for (int i = 0; i < 3; i++)
        begin
          if (q.c_cnt[i*5 +: 5] == q.c_cfg[i*5 +: 5])
          begin
            d.c_cnt[i*5 +: 5] = 5'h00;
            d.clk[i]          = ~q.clk[i];
          end
          else
            d.c_cnt[i*5 +: 5] = q.c_cnt[i*5 +: 5] + 5'h01;
        end
      end
      // pre-scaler on the selected reference
      if (ref_rise)
      begin
        if (q.n_cnt >= q.n_cfg)
        begin
          d.n_cnt = 2'h0;
          fref    = 1'b1;
        end
        else
          d.n_cnt = q.n_cnt + 2'h1;
      end
      // phase-frequency compare once per divided reference edge
      if (fref)
      begin
        d.fb_cnt = tick ? 6'h01 : 6'h00;
        if (f.det_enable)
        begin
          // too few ticks: speed up; too many: slow down
          if (q.fb_cnt < m_val && q.period > PPC_PERIOD_MIN)
            d.period = q.period - 16'h0001;
          else if (q.fb_cnt > m_val && q.period < PPC_PERIOD_MAX)
            d.period = q.period + 16'h0001;
        end
        if (q.fb_cnt == m_val)
        begin
          if (q.match == PPC_LOCK_CMP)
            d.locked = 1'b1;
          else
            d.match = q.match + 4'h1;
        end
        else
        begin
          d.match  = 4'h0;
          d.locked = 1'b0;
        end
      end
    end

    // a lowered pre-scale setting must not strand the counter above it
    if (d.n_cnt > d.n_cfg)
      d.n_cnt = 2'h0;

    // external pin mirrors c2 alongside the global copy
    d.ext = d.clk[2] & d.ext_en;

    // sticky events, set wins over a same-cycle clear
    ev[PPC_IRQ_GAIN] = d.locked & ~q.locked;
    ev[PPC_IRQ_LOST] = ~d.locked & q.locked;
    d.irq_stat = (q.irq_stat & ~w1c) | ev;
    d.irq      = |(d.irq_stat & d.irq_mask);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      q          <= '0;
      q.period   <= PPC_PERIOD_RST;
      q.n_cfg    <= PPC_N_RST;
      q.m_cfg    <= PPC_M_RST;
      q.c_cfg    <= PPC_C_RST;
      q.ext_en   <= PPC_EXT_RST;
      q.irq_mask <= PPC_MASK_RST;
      q.waitreq  <= 1'b1;
    end
    else
      q <= d;
  end

  // outputs straight from flops
  assign pll_clk_out             = q.clk;
  assign ext_clk_out             = q.ext;
  assign locked_out              = q.locked;
  assign irq_out                 = q.irq;
  assign avs_rsp_out.waitrequest = q.waitreq;
  assign avs_rsp_out.readdata    = q.rdata;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_post_wrap;
    run && !restart && !sw_rise && tick && (q.c_cnt[4:0] == q.c_cfg[4:0]);
  endsequence

  chk_off_quiet: assert property (
    !f.enable |=> (q.clk == 3'h0) && !q.locked && !q.ext)
    else $error("clocks or lock active while disabled");
  chk_restart_cnt: assert property (
    restart |=> (q.n_cnt == 2'h0) && (q.match == 4'h0) && !q.locked)
    else $error("restart did not begin fresh acquisition");
  chk_reset_cnt: assert property (
    f.cnt_reset |=> (q.c_cnt == 15'h0000) && (q.fb_cnt == 6'h00)
                    && (q.n_cnt == 2'h0) && (q.clk == 3'h0))
    else $error("counters not restored under reset");
  chk_det_hold: assert property (
    (run && !f.det_enable) |=> (q.period == $past(q.period)))
    else $error("oscillator moved with detector off");
  chk_free_toggle: assert property (
    s_post_wrap |=> (q.clk[0] != $past(q.clk[0])))
    else $error("c0 failed to toggle on wrap");
  chk_lock_hold: assert property (
    q.locked |-> (q.match == PPC_LOCK_CMP))
    else $error("lock high without enough matched compares");
  chk_lock_gate: assert property (
    (!f.enable || f.cnt_reset) |=> !locked_out)
    else $error("lock high while disabled or reset");
  chk_ext_mirror: assert property (
    ##1 (ext_clk_out == (q.clk[2] & q.ext_en)))
    else $error("external pin differs from c2");
  chk_ref_swap: assert property (
    (run && sw_rise && q.run_prev) |=> (q.sel != $past(q.sel)) && !q.locked)
    else $error("switchover did not swap reference");
  chk_pre_range: assert property (
    q.n_cnt <= q.n_cfg)
    else $error("pre-scale counter beyond setting");
  chk_bus_answer: assert property (
    (req && q.waitreq) |=> !avs_rsp_out.waitrequest ##1 avs_rsp_out.waitrequest)
    else $error("bus answer not one cycle after request");

endmodule : ppc_pll_ctrl

// File: ppc_fabric_model.sv
// fabric side model: control pin levels and both reference clocks
`timescale 1ns/1ps
module ppc_fabric_model
#(
  parameter int HALF = 40
)
(
  input  wire logic          ref_clk_in,
  input  wire logic          reset_in,
  input  wire logic [3:0]    ctl_in,
  input  wire logic          ref_run_in,
  output ppc_pkg::ppc_pins_t pins_out
);
  import ppc_pkg::*;

  logic [7:0] cnt_q;

  // ************************************************************
  // pins change just after an edge, refs halt when told to
  // ************************************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      pins_out <= '0;
      cnt_q    <= 8'h00;
    end
    else
    begin
      pins_out.enable     <= ctl_in[0];
      pins_out.cnt_reset  <= ctl_in[1];
      pins_out.det_enable <= ctl_in[2];
      pins_out.switch_req <= ctl_in[3];
      // stopped reference stands still, as a lost input clock would
      if (ref_run_in)
      begin
        if (cnt_q == 8'(HALF - 1))
        begin
          cnt_q            <= 8'h00;
          pins_out.ref_pri <= ~pins_out.ref_pri;
          pins_out.ref_sec <= ~pins_out.ref_sec;
        end
        else
        begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
endmodule : ppc_fabric_model

// File: tb_pll_port_control.sv
// self-checking bench for the pll port control block
`timescale 1ns/1ps
module tb_pll_port_control;
  import ppc_pkg::*;
  logic        ref_clk_in;
  logic        reset_in;
  logic [3:0]  ctl;
  logic        ref_run;
  ppc_pins_t   pins;
  ppc_av_req_t req;
  ppc_av_rsp_t rsp;
  logic [2:0]  pclk;
  logic        ext;
  logic        lck;
  logic        irq;
  logic [31:0] rd;
  logic [3:0]  tg;
  logic [15:0] per;
  int          num_errors;
  int          samples_checked;

  ppc_fabric_model #(.HALF(40)) model (.ref_clk_in(ref_clk_in),
    .reset_in(reset_in), .ctl_in(ctl), .ref_run_in(ref_run),
    .pins_out(pins));
  ppc_pll_ctrl uut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .pins_in(pins), .avs_req_in(req), .avs_rsp_out(rsp),
    .pll_clk_out(pclk), .ext_clk_out(ext), .locked_out(lck),
    .irq_out(irq));

  // ************************************************************
  // helpers
  // ************************************************************
  task stop_test();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk

  // one avalon cycle; request held until waitrequest seen low
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk_in);
    req.read      <= ~wr;
    req.write     <= wr;
    req.address   <= a;
    req.writedata <= d;
    for (i = 0; i < 50; i++)
    begin
      @(posedge ref_clk_in);
      if (rsp.waitrequest === 1'b0)
        break;
    end
    if (i == 50)
    begin
      num_errors++;
      stop_test();
    end
    rd = rsp.readdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask : bus

  task rchk(input logic [4:0] a, input logic [31:0] m,
            input logic [31:0] e, input string w);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e, w);
  endtask : rchk

  task settle(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : settle

  // which of {ext, c2, c1, c0} moved during n cycles
  task seen(input int n);
    logic [3:0] p;
    tg = 4'h0;
    p  = {ext, pclk};
    repeat (n)
    begin
      @(posedge ref_clk_in);
      tg = tg | (p ^ {ext, pclk});
      p  = {ext, pclk};
    end
  endtask : seen

  task quiet(input int n);
    repeat (n)
    begin
      @(posedge ref_clk_in);
      chk({27'h0, lck, ext, pclk}, 32'h0, "outputs not quiet");
    end
  endtask : quiet

  // lock must hold 16 cycles: early pulses are not taken as final
  task wait_lock();
    int i;
    int run;
    run = 0;
    for (i = 0; i < 20000 && run < 16; i++)
    begin
      @(posedge ref_clk_in);
      run = (lck === 1'b1) ? run + 1 : 0;
    end
    chk(32'(run >= 16), 32'h1, "no lock");
    if (run < 16)
      stop_test();
  endtask : wait_lock

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_regs();
    rchk(PPC_REG_CFG, 32'hFFFFFFFF, 32'h00000700, "cfg reset");
    rchk(PPC_REG_DIV, 32'hFFFFFFFF, 32'h0, "div reset");
    rchk(PPC_REG_STATUS, 32'hFFFFFFFF, 32'h00080000, "status reset");
    rchk(PPC_REG_IRQ_MASK, 32'hFFFFFFFF, 32'h0, "mask reset");
    rchk(PPC_REG_OUT_CFG, 32'hFFFFFFFF, 32'h0, "outcfg reset");
    bus(1'b1, 5'h18, 32'hFFFFFFFF);
    rchk(5'h18, 32'hFFFFFFFF, 32'h0, "unmapped");
    bus(1'b1, PPC_REG_STATUS, 32'hFFFFFFFF);
    rchk(PPC_REG_STATUS, 32'hFFFFFFFF, 32'h00080000, "status ro");
    bus(1'b1, PPC_REG_CFG, 32'hFFFFFFFF);
    rchk(PPC_REG_CFG, 32'hFFFFFFFF, 32'h00001F03, "cfg max");
    bus(1'b1, PPC_REG_DIV, 32'hFFFFFFFF);
    rchk(PPC_REG_DIV, 32'hFFFFFFFF, 32'h001F1F1F, "div max");
    bus(1'b1, PPC_REG_CFG, 32'h00000700);
    bus(1'b1, PPC_REG_DIV, 32'h0);
  endtask : t_regs

  task t_lock();
    ctl <= 4'b0101;
    wait_lock();
    seen(60);
    chk({28'h0, tg}, 32'h7, "c0..c2 only");
    rchk(PPC_REG_STATUS, 32'hF, 32'hD, "locked on primary");
    rchk(PPC_REG_IRQ_STAT, 32'h1, 32'h1, "gain flag");
  endtask : t_lock

  task t_irq();
    bus(1'b1, PPC_REG_IRQ_MASK, 32'h1);
    settle(3);
    chk({31'h0, irq}, 32'h1, "irq high");
    bus(1'b1, PPC_REG_IRQ_STAT, 32'h1);
    settle(3);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rchk(PPC_REG_IRQ_STAT, 32'h1, 32'h0, "gain cleared");
  endtask : t_irq

  task t_ext();
    bus(1'b1, PPC_REG_OUT_CFG, 32'h1);
    seen(60);
    chk({28'h0, tg}, 32'hF, "ext follows c2");
    bus(1'b1, PPC_REG_OUT_CFG, 32'h0);
    settle(3);
    seen(60);
    chk({28'h0, tg}, 32'h7, "ext off");
  endtask : t_ext

  task t_enable();
    ctl <= 4'b0100;
    settle(8);
    quiet(40);
    rchk(PPC_REG_IRQ_STAT, 32'h2, 32'h2, "lost flag");
    ctl <= 4'b0101;
    wait_lock();
  endtask : t_enable

  task t_reset();
    ctl <= 4'b0111;
    settle(8);
    quiet(40);
    ctl <= 4'b0101;
    settle(8);
    chk({31'h0, lck}, 32'h0, "lock after reset");
    wait_lock();
  endtask : t_reset

  task t_switch();
    bus(1'b1, PPC_REG_IRQ_STAT, 32'h7);
    ctl <= 4'b1101;
    settle(8);
    chk({31'h0, lck}, 32'h0, "lock kept over switch");
    rchk(PPC_REG_STATUS, 32'h2, 32'h2, "secondary selected");
    rchk(PPC_REG_IRQ_STAT, 32'h4, 32'h4, "switch flag");
    ctl <= 4'b0101;
    wait_lock();
  endtask : t_switch

  task t_det();
    ctl <= 4'b0001;
    settle(8);
    bus(1'b0, PPC_REG_STATUS, 32'h0);
    per = rd[31:16];
    ref_run <= 1'b0;
    settle(300);
    seen(60);
    chk({28'h0, tg}, 32'h7, "clocks run without ref");
    rchk(PPC_REG_STATUS, 32'hFFFF0000, {per, 16'h0}, "period held");
    ref_run <= 1'b1;
    ctl <= 4'b0101;
  endtask : t_det

  // n = 2, c = 1, 2, 4: tick every 20 cycles, toggles over 800 cycles
  task t_div();
    int         k [3];
    logic [2:0] p;
    settle(1);
    ctl <= 4'b0100;
    settle(8);
    bus(1'b1, PPC_REG_CFG, 32'h00000701);
    bus(1'b1, PPC_REG_DIV, 32'h00030100);
    ctl <= 4'b0101;
    wait_lock();
    k = '{0, 0, 0};
    p = pclk;
    repeat (800)
    begin
      @(posedge ref_clk_in);
      for (int i = 0; i < 3; i++)
      begin
        if (p[i] != pclk[i])
          k[i]++;
      end
      p = pclk;
    end
    chk(32'(k[0]), 32'h28, "c0 rate");
    chk(32'(k[1]), 32'h14, "c1 rate");
    chk(32'(k[2]), 32'h0A, "c2 rate");
  endtask : t_div

  // ************************************************************
  // clock, reset and main sequence
  // ************************************************************
  initial
  begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  initial
  begin
    num_errors      = 0;
    samples_checked = 0;
    reset_in        = 1'b1;
    ctl             = 4'h0;
    ref_run         = 1'b1;
    req             = '0;
    settle(20);
    reset_in <= 1'b0;
    settle(2);
    t_regs();
    t_lock();
    t_irq();
    t_ext();
    t_enable();
    t_reset();
    t_switch();
    t_det();
    t_div();
    stop_test();
  end
endmodule : tb_pll_port_control
